//--- inc/sp_alarm_pkg.sv
package sp_alarm_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS   = 8'h00;  // enables, reset sources, colour
  localparam logic [7:0] STATUS_OFS = 8'h04;  // live output state
  localparam logic [7:0] CMD_OFS    = 8'h08;  // serial reset command
  localparam logic [7:0] SP_BASE    = 8'h10;  // first setpoint block
  localparam logic [7:0] SP_STRIDE  = 8'h10;  // bytes per setpoint block
  localparam logic [3:0] VAL_OFS    = 4'h0;   // setpoint value
  localparam logic [3:0] HYST_OFS   = 4'h4;   // hysteresis
  localparam logic [3:0] DLY_OFS    = 4'h8;   // on delay [12:0], off delay [28:16]
  localparam logic [3:0] CFG_OFS    = 4'hC;   // per-setpoint configuration

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_SP2_EN   = 0;
  localparam int CTRL_KEY_DSP  = 1;
  localparam int CTRL_USER_DSP = 2;
  localparam int CTRL_GREEN    = 3;
  localparam int CTRL_DP_LSB   = 4;
  localparam int DLY_OFF_LSB   = 16;

  // ----------------------------------------------------------------
  // limits and reset values
  // ----------------------------------------------------------------
  localparam logic signed [23:0] SP_MAX    = 24'sh01869F;  // 99999
  localparam logic signed [23:0] SP_MIN    = -24'sh004E1F; // -19999
  localparam logic [15:0]        HYST_MIN  = 16'h0001;     // 1
  localparam logic [15:0]        HYST_MAX  = 16'hEA5F;     // 59999
  localparam logic [12:0]        DLY_MAX   = 13'h176F;     // 5999 tenths
  localparam logic signed [19:0] SP_RST    = 20'sh00064;   // 100
  localparam logic [15:0]        HYST_RST  = 16'h0002;
  localparam logic [31:0]        CTRL_RST  = 32'h00000000;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_NS      = 8;
  localparam int TENTH_MS    = 100;  // delay unit
  localparam int DEBOUNCE_MS = 50;   // user input settle time
  localparam int TENTH_CYC   = TENTH_MS * 1000000 / CLK_NS;
  localparam int DEB_CYC     = DEBOUNCE_MS * 1000000 / CLK_NS;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    high_acting_unbalanced = 2'b00,
    low_acting_unbalanced  = 2'b01,
    high_acting_balanced   = 2'b10,
    low_acting_balanced    = 2'b11
  } action_type;

  typedef enum logic [1:0] {
    automatic_reset_mode       = 2'b00,
    latch_immediate_reset_mode = 2'b01,
    latch_delayed_reset_mode   = 2'b10,
    reserved_mode              = 2'b11
  } reset_mode_type;

  typedef struct packed {
    logic           color_chg;   // [7] colour follows output
    logic           burnout_on;  // [6] state on open probe
    logic           standby_en;  // [5]
    logic           rst_w_disp;  // [4] output reset with display reset
    reset_mode_type mode;        // [3:2]
    action_type     action;      // [1:0]
  } sp_cfg_type;

endpackage : sp_alarm_pkg

//--- design/sp_alarm.sv
// Local design decisions: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module sp_alarm #(
  parameter int NUM_SP    = 2,                           // outputs on widest card
  parameter int TENTH_CYC = sp_alarm_pkg::TENTH_CYC,     // clocks per 0.1 s
  parameter int DEB_CYC   = sp_alarm_pkg::DEB_CYC        // clocks per debounce
) (
  // clock and reset
  input  wire logic               hclk,
  input  wire logic               hresetn,
  // ahb-lite slave
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic                    hresp,
  output logic [31:0]             hrdata,
  // measurement side, same clock
  input  wire logic signed [19:0] display_value,
  input  wire logic               display_update,
  input  wire logic               display_shows_input,
  // pins from outside
  input  wire logic [1:0]         card_count,
  input  wire logic               probe_open,
  input  wire logic               panel_key_n,
  input  wire logic               external_user_input_n,
  input  wire logic               backlit,
  // outputs
  output logic [NUM_SP-1:0]       sp_out,
  output logic                    backlight_green
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (NUM_SP < 1 || NUM_SP > 2) begin : g_bad_sp
    $error("NUM_SP must be 1 or 2");
  end
  if (TENTH_CYC < 2 || DEB_CYC < 2) begin : g_bad_cyc
    $error("cycle counts must be at least 2");
  end

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // saturate a signed write to a range
  function automatic logic signed [23:0] clamp(input logic signed [23:0] v,
                                               input logic signed [23:0] lo,
                                               input logic signed [23:0] hi);
    if (v < lo) return lo;
    else if (v > hi) return hi;
    else return v;
  endfunction : clamp

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [5:0] pin_s1_q;  // first stage, read only by second
  logic [5:0] pin_s2_q;  // usable pin levels
  logic [1:0] card_s;    // fitted outputs
  logic       probe_s;   // probe open
  logic       key_s;     // key level, active low
  logic       user_s;    // user input level, active low
  logic       backlit_s; // backlit unit strap

  // two flops on every pin
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // key, user and strap rest high; probe and card count rest low
      pin_s1_q <= 6'h38;
      pin_s2_q <= 6'h38;
    end else begin
      pin_s1_q <= {backlit, external_user_input_n, panel_key_n, probe_open, card_count};
      pin_s2_q <= pin_s1_q;
    end
  end
  assign card_s    = pin_s2_q[1:0];
  assign probe_s   = pin_s2_q[2];
  assign key_s     = pin_s2_q[3];
  assign user_s    = pin_s2_q[4];
  assign backlit_s = pin_s2_q[5];

  // ----------------------------------------------------------------
  // user input debounce and reset events
  // ----------------------------------------------------------------
  logic [31:0] deb_cnt_q;   // time the raw level has differed
  logic        user_db_q;   // debounced level, active low
  logic        user_prev_q; // for edge detect
  logic        key_prev_q;  // for edge detect
  logic        user_press;  // debounced activation
  logic        key_press;   // key activation

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      deb_cnt_q <= 32'h00000000;
      user_db_q <= 1'b1;
    end else if (user_s == user_db_q) begin
      deb_cnt_q <= 32'h00000000;
    end else if (deb_cnt_q == 32'(DEB_CYC - 1)) begin
      deb_cnt_q <= 32'h00000000;
      user_db_q <= user_s;
    end else begin
      deb_cnt_q <= deb_cnt_q + 32'h00000001;
    end
  end

  // previous levels for press edges
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      user_prev_q <= 1'b1;
      key_prev_q  <= 1'b1;
    end else begin
      user_prev_q <= user_db_q;
      key_prev_q  <= key_s;
    end
  end
  assign user_press = user_prev_q & ~user_db_q;
  assign key_press  = key_prev_q & ~key_s;

  // ----------------------------------------------------------------
  // timebase
  // ----------------------------------------------------------------
  logic [31:0] tenth_cnt_q; // free-running divider
  logic        tenth_tick;  // one pulse per 0.1 s

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) tenth_cnt_q <= 32'h00000000;
    else if (tenth_tick) tenth_cnt_q <= 32'h00000000;
    else tenth_cnt_q <= tenth_cnt_q + 32'h00000001;
  end
  assign tenth_tick = (tenth_cnt_q == 32'(TENTH_CYC - 1));

  // ----------------------------------------------------------------
  // registers and bus slave
  // ----------------------------------------------------------------
  logic [31:0]             ctrl_q;                // global control
  logic signed [19:0]      sp_val_q  [NUM_SP];    // thresholds
  logic [15:0]             hyst_q    [NUM_SP];    // hysteresis
  logic [12:0]             on_dly_q  [NUM_SP];    // tenths
  logic [12:0]             off_dly_q [NUM_SP];    // tenths
  sp_alarm_pkg::sp_cfg_type cfg_q    [NUM_SP];    // per-setpoint mode
  logic                    dph_wr_q;              // write data phase pending
  logic [7:0]              dph_addr_q;            // its address
  logic [NUM_SP-1:0]       ser_rst;               // serial reset command pulse
  logic                    addr_ph;               // accepted address phase
  logic [31:0]             rd_d;                  // read data next
  logic [NUM_SP-1:0]       out_q, pend_q, stby_q; // per-setpoint state
  logic [NUM_SP-1:0]       pin_d;                 // next output pins
  logic                    color_q;               // colour toggle state
  logic [1:0]              spi_w;                 // setpoint index of write
  logic [1:0]              spi_r;                 // setpoint index of read

  assign addr_ph = hsel & htrans[1] & hready;
  assign spi_w   = 2'(dph_addr_q[5:4] - 2'h1);
  assign spi_r   = 2'(haddr[5:4] - 2'h1);

  // address phase capture; always zero wait, always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_wr_q   <= 1'b0;
      dph_addr_q <= 8'h00;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
      hrdata     <= 32'h00000000;
    end else begin
      dph_wr_q   <= addr_ph & hwrite;
      dph_addr_q <= haddr[7:0];
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
      if (addr_ph && !hwrite) hrdata <= rd_d;
    end
  end

  // read mux, unmapped reads as zero
  always_comb begin
    rd_d = 32'h00000000;
    if (haddr[7:0] == sp_alarm_pkg::CTRL_OFS) begin
      rd_d = ctrl_q;
    end else if (haddr[7:0] == sp_alarm_pkg::STATUS_OFS) begin
      rd_d = {22'h000000, backlight_green, probe_s, card_s,
              2'(stby_q), 2'(pend_q), 2'(sp_out)};
    end else if (haddr[7:6] == 2'b00 && haddr[5:4] != 2'b00 && 32'(spi_r) < NUM_SP) begin
      unique case (haddr[3:0])
        sp_alarm_pkg::VAL_OFS:  rd_d = 32'(signed'(sp_val_q[spi_r[0]]));
        sp_alarm_pkg::HYST_OFS: rd_d = {16'h0000, hyst_q[spi_r[0]]};
        sp_alarm_pkg::DLY_OFS:  rd_d = {3'h0, off_dly_q[spi_r[0]], 3'h0, on_dly_q[spi_r[0]]};
        sp_alarm_pkg::CFG_OFS:  rd_d = {24'h000000, cfg_q[spi_r[0]]};
        default:                rd_d = 32'h00000000;
      endcase
    end
  end

  // register writes in the data phase; values saturate to legal range
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= sp_alarm_pkg::CTRL_RST;
      for (int i = 0; i < NUM_SP; i++) begin
        sp_val_q[i]  <= sp_alarm_pkg::SP_RST;
        hyst_q[i]    <= sp_alarm_pkg::HYST_RST;
        on_dly_q[i]  <= 13'h0000;
        off_dly_q[i] <= 13'h0000;
        cfg_q[i]     <= '0;
      end
    end else if (dph_wr_q) begin
      if (dph_addr_q == sp_alarm_pkg::CTRL_OFS) ctrl_q <= {25'h0000000, hwdata[6:0]};
      for (int i = 0; i < NUM_SP; i++) begin
        if (dph_addr_q[7:6] == 2'b00 && dph_addr_q[5:4] != 2'b00 && spi_w == 2'(i)) begin
          unique case (dph_addr_q[3:0])
            sp_alarm_pkg::VAL_OFS:  sp_val_q[i] <= 20'(clamp(24'(signed'(hwdata[23:0])),
                                      sp_alarm_pkg::SP_MIN, sp_alarm_pkg::SP_MAX));
            sp_alarm_pkg::HYST_OFS: hyst_q[i] <= 16'(clamp(24'(hwdata[15:0]),
                                      24'(sp_alarm_pkg::HYST_MIN), 24'(sp_alarm_pkg::HYST_MAX)));
            sp_alarm_pkg::DLY_OFS: begin
              on_dly_q[i]  <= 13'(clamp(24'(hwdata[12:0]), 24'h0, 24'(sp_alarm_pkg::DLY_MAX)));
              off_dly_q[i] <= 13'(clamp(24'(hwdata[28:16]), 24'h0, 24'(sp_alarm_pkg::DLY_MAX)));
            end
            sp_alarm_pkg::CFG_OFS:  cfg_q[i] <= hwdata[7:0];
            default: ;
          endcase
        end
      end
    end
  end

  // serial reset command: write a one per setpoint
  always_comb begin
    for (int i = 0; i < NUM_SP; i++) begin
      ser_rst[i] = dph_wr_q && dph_addr_q == sp_alarm_pkg::CMD_OFS && hwdata[i];
    end
  end

  // ----------------------------------------------------------------
  // trigger points and per-setpoint state
  // ----------------------------------------------------------------
  logic [NUM_SP-1:0] active;     // card fitted and enabled
  logic [NUM_SP-1:0] on_c;       // value beyond on trigger
  logic [NUM_SP-1:0] off_c;      // value beyond off trigger
  logic [NUM_SP-1:0] req_q;      // manual reset waiting for update
  logic [NUM_SP-1:0] req_now;    // manual reset this cycle
  logic [NUM_SP-1:0] block_q;    // held off until retrigger
  logic [12:0]       tmr_q [NUM_SP]; // delay timers in tenths
  logic              man_rst;    // key or user reset aimed at outputs

  always_comb begin
    man_rst = (key_press && (!ctrl_q[sp_alarm_pkg::CTRL_KEY_DSP] || display_shows_input))
           || (user_press && (!ctrl_q[sp_alarm_pkg::CTRL_USER_DSP] || display_shows_input));
    for (int i = 0; i < NUM_SP; i++) begin
      req_now[i] = ser_rst[i] || (man_rst &&
        (cfg_q[i].rst_w_disp ||
         !(key_press ? ctrl_q[sp_alarm_pkg::CTRL_KEY_DSP] : ctrl_q[sp_alarm_pkg::CTRL_USER_DSP])));
    end
  end

  // trigger points; display units share the display decimal point
  always_comb begin
    logic signed [23:0] v, sp, h, hh;
    v = 24'h000000;
    sp = 24'h000000;
    h = 24'h000000;
    hh = 24'h000000;
    for (int i = 0; i < NUM_SP; i++) begin
      v  = 24'(display_value);
      sp = 24'(sp_val_q[i]);
      h  = 24'(hyst_q[i]);
      hh = h >>> 1;
      active[i] = (32'(card_s) > i) && (i != 1 || ctrl_q[sp_alarm_pkg::CTRL_SP2_EN]);
      unique case (cfg_q[i].action)
        sp_alarm_pkg::high_acting_unbalanced: begin on_c[i] = v >= sp; off_c[i] = v <= sp - h; end
        sp_alarm_pkg::low_acting_unbalanced:  begin on_c[i] = v <= sp; off_c[i] = v >= sp + h; end
        sp_alarm_pkg::high_acting_balanced:   begin on_c[i] = v >= sp + hh; off_c[i] = v <= sp - hh; end
        sp_alarm_pkg::low_acting_balanced:    begin on_c[i] = v <= sp - hh; off_c[i] = v >= sp + hh; end
      endcase
    end
  end

  // manual requests held until the next update; a new one wins the clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) req_q <= '0;
    else req_q <= (display_update ? '0 : req_q) | req_now;
  end

  // delay timers count while the pending direction holds
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < NUM_SP; i++) tmr_q[i] <= 13'h0000;
    end else begin
      for (int i = 0; i < NUM_SP; i++) begin
        if (display_update && !(out_q[i] ? off_c[i] : on_c[i])) tmr_q[i] <= 13'h0000;
        else if (tenth_tick && tmr_q[i] != sp_alarm_pkg::DLY_MAX) tmr_q[i] <= tmr_q[i] + 13'h0001;
      end
    end
  end

  // output state moves only on display update
  // power-up clears latch and pending reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_q   <= '0;
      pend_q  <= '0;
      block_q <= '0;
      stby_q  <= '1;
    end else if (display_update) begin
      for (int i = 0; i < NUM_SP; i++) begin
        logic rq, on_ok, off_ok;
        rq     = req_q[i] | req_now[i];
        on_ok  = on_c[i] && tmr_q[i] >= on_dly_q[i] && !block_q[i];
        off_ok = off_c[i] && tmr_q[i] >= off_dly_q[i];
        if (off_c[i]) block_q[i] <= 1'b0;
        if (off_c[i]) stby_q[i] <= 1'b0;
        if (!active[i] || (stby_q[i] && cfg_q[i].standby_en)) begin
          out_q[i]  <= 1'b0;
          pend_q[i] <= 1'b0;
        end else if (!out_q[i]) begin
          out_q[i]  <= on_ok;
          pend_q[i] <= 1'b0;
        end else begin
          unique case (cfg_q[i].mode)
            sp_alarm_pkg::automatic_reset_mode: begin
              if (rq) block_q[i] <= 1'b1;
              if (rq || off_ok) out_q[i] <= 1'b0;
            end
            sp_alarm_pkg::latch_immediate_reset_mode: begin
              if (rq) begin
                out_q[i]   <= 1'b0;
                block_q[i] <= 1'b1;
              end
            end
            sp_alarm_pkg::latch_delayed_reset_mode: begin
              if ((pend_q[i] || rq) && off_ok) begin
                out_q[i]  <= 1'b0;
                pend_q[i] <= 1'b0;
              end else if (rq) begin
                pend_q[i] <= 1'b1;
              end
            end
            default: out_q[i] <= 1'b0;
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // output pins and backlight
  // ----------------------------------------------------------------
  // burn-out overrides the comparison
  always_comb begin
    for (int i = 0; i < NUM_SP; i++) begin
      pin_d[i] = active[i] && (probe_s ? cfg_q[i].burnout_on : out_q[i]);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) sp_out <= '0;
    else sp_out <= pin_d;
  end

  // colour flips once per cycle in which any colour-enabled output changes, on backlit units only
  always_ff @(posedge hclk or negedge hresetn) begin
    logic chg;
    if (!hresetn) begin
      color_q         <= 1'b0;
      backlight_green <= 1'b0;
    end else begin
      chg = 1'b0;
      for (int i = 0; i < NUM_SP; i++) chg = chg | ((pin_d[i] ^ sp_out[i]) & cfg_q[i].color_chg);
      color_q         <= color_q ^ (chg & backlit_s);
      backlight_green <= ctrl_q[sp_alarm_pkg::CTRL_GREEN] ^ color_q;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_no_card_off: assert property (!active[0] |=> !sp_out[0])
    else $error("output driven with no card");
  chk_sp2_disabled: assert property (
    (NUM_SP < 2 || !ctrl_q[sp_alarm_pkg::CTRL_SP2_EN]) |=> !sp_out[NUM_SP-1] || NUM_SP < 2)
    else $error("second output on while disabled");
  chk_sp_bound: assert property (sp_val_q[0] <= 20'sh1869F)
    else $error("setpoint above bound");
  chk_hyst_range: assert property (hyst_q[0] >= 16'h0001 && hyst_q[0] <= 16'hEA5F)
    else $error("hysteresis out of range");
  chk_on_delay: assert property (
    (display_update && !out_q[0] && tmr_q[0] < on_dly_q[0]) |=> !out_q[0])
    else $error("output on before its delay");
  chk_auto_reset: assert property (
    (display_update && out_q[0] && active[0] && !stby_q[0]
     && cfg_q[0].mode == sp_alarm_pkg::automatic_reset_mode && req_q[0]) |=> !out_q[0] ##1 !sp_out[0]
     || probe_s)
    else $error("manual reset ignored");
  chk_latch_hold: assert property (
    (out_q[0] && active[0] && cfg_q[0].mode == sp_alarm_pkg::latch_immediate_reset_mode
     && !req_q[0] && !req_now[0] && !(stby_q[0] && cfg_q[0].standby_en)) |=> out_q[0])
    else $error("latched output dropped");
  chk_pend_hold: assert property (
    (display_update && out_q[0] && active[0] && req_q[0] && !off_c[0] && !stby_q[0]
     && cfg_q[0].mode == sp_alarm_pkg::latch_delayed_reset_mode) |=> out_q[0] && pend_q[0])
    else $error("delayed reset applied early");
  chk_burnout: assert property ((probe_s && active[0]) |=> sp_out[0] == $past(cfg_q[0].burnout_on))
    else $error("burn-out state wrong");
  chk_debounce: assert property ($changed(user_db_q) |-> $past(user_s, 2) == user_db_q)
    else $error("user input changed without settling");

  cov_output_on:  cover property (!sp_out[0] ##1 sp_out[0]);
  cov_latch_rst:  cover property (out_q[0] && req_q[0] && display_update ##1 !out_q[0]);
  cov_color_flip: cover property ($changed(backlight_green));

endmodule : sp_alarm

//--- verification/panel_model.sv
`timescale 1ns/1ps
module panel_model (
  // commands from the bench
  input  wire logic       press,
  input  wire logic [1:0] fit,
  input  wire logic       open,
  input  wire logic       user,
  // pins into the meter
  output logic            panel_key_n,
  output logic            external_user_input_n,
  output logic [1:0]      card_count,
  output logic            probe_open,
  output logic            backlit
);
  // key is active low, idle high by its pull-up
  assign panel_key_n           = ~press;
  assign card_count            = fit;
  assign probe_open            = open;
  // user input rests on its pull-up, pulled low while held; unit is backlit
  assign external_user_input_n = ~user;
  assign backlit               = 1'b1;
endmodule : panel_model

//--- verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  // ----------------------------------------------------------
  // signals
  // ----------------------------------------------------------
  logic hclk, hresetn = 0, hsel = 0, hwrite = 0, display_update = 0;
  logic press = 0, open = 0, user = 0, display_shows_input = 1, hreadyout, hresp;
  logic panel_key_n, external_user_input_n, probe_open, backlit, backlight_green;
  logic [1:0] htrans = 2'h0, fit = 2'h0, card_count, sp_out;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic signed [19:0] display_value = 20'sh0;
  wire logic hready = hreadyout;
  int compares, miscompares, cycles;
  // rows: bit 20 expected output, low bits displayed value
  logic [20:0] rows [6] = '{21'h00063, 21'h100064, 21'h100063, 21'h00062,
                            21'h100096, 21'h00062};
  panel_model i_panel (.press, .fit, .open, .user, .panel_key_n, .external_user_input_n,
                       .card_count, .probe_open, .backlit);
  sp_alarm #(.TENTH_CYC(10), .DEB_CYC(4)) i_dut (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata,
    .display_value, .display_update, .display_shows_input, .card_count, .probe_open,
    .panel_key_n, .external_user_input_n, .backlit, .sp_out, .backlight_green);
  // ----------------------------------------------------------
  // tasks
  // ----------------------------------------------------------
  task automatic bus(input logic w, input logic [31:0] a, d);
    @(posedge hclk);
    {hsel, htrans, haddr, hwrite} <= {1'b1, 2'h2, a, w};
    do @(posedge hclk); while (hready !== 1'b1);
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus
  // one evaluation instant, then let the pin flop settle
  task automatic upd(input logic [19:0] v);
    @(posedge hclk);
    {display_value, display_update} <= {v, 1'b1};
    @(posedge hclk);
    display_update <= 1'b0;
    repeat (2) @(posedge hclk);
  endtask : upd
  task automatic chk(input logic [31:0] got, exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wrap_up;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  // ----------------------------------------------------------
  // clock, watchdog, sequence
  // ----------------------------------------------------------
  initial begin
    hclk = 0;
    forever #4 hclk = ~hclk;
  end
  // a hang counts as a mismatch
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      wrap_up();
    end
  end
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    chk(sp_out, 0);
    bus(0, 32'h10, 0); chk(rd, 32'h64);
    bus(0, 32'h80, 0); chk(rd, 0);
    // no card fitted: nothing switches
    upd(20'h96);
    chk(sp_out, 0);
    fit <= 2'h2;
    // sp2 left disabled, so only bit 0 may move
    for (int i = 0; i < 6; i++) begin
      upd(rows[i][19:0]);
      chk(sp_out, {1'b0, rows[i][20]});
    end
    // low acting, balanced band of one either side of 100
    bus(1, 32'h1C, 32'h3);
    upd(20'h63);
    chk(sp_out, 1);
    upd(20'h64);
    chk(sp_out, 1);
    upd(20'h65);
    chk(sp_out, 0);
    // on delay of two tenths, timed from the last update off the trigger
    bus(1, 32'h1C, 32'h0);
    bus(1, 32'h18, 32'h2);
    upd(20'h62);
    upd(20'h96);
    chk(sp_out, 0);
    repeat (30) @(posedge hclk);
    upd(20'h96);
    chk(sp_out, 1);
    bus(1, 32'h18, 32'h0);
    // second setpoint follows its enable
    bus(1, 32'h0, 32'h1);
    upd(20'h96);
    chk(sp_out, 3);
    bus(1, 32'h0, 32'h0);
    upd(20'h96);
    chk(sp_out, 1);
    // immediate latch holds until key reset
    bus(1, 32'h1C, 32'h4);
    upd(20'h96);
    upd(20'h32);
    chk(sp_out, 1);
    press <= 1'b1;
    repeat (4) @(posedge hclk);
    press <= 1'b0;
    upd(20'h32);
    chk(sp_out, 0);
    // auto mode: a short user glitch is ignored, a held press resets
    bus(1, 32'h1C, 32'h0);
    upd(20'h32);
    upd(20'h96);
    chk(sp_out, 1);
    user <= 1'b1;
    @(posedge hclk);
    user <= 1'b0;
    repeat (8) @(posedge hclk);
    upd(20'h96);
    chk(sp_out, 1);
    user <= 1'b1;
    repeat (8) @(posedge hclk);
    user <= 1'b0;
    repeat (8) @(posedge hclk);
    upd(20'h96);
    chk(sp_out, 0);
    upd(20'h96);
    chk(sp_out, 0);
    // delayed latch: the reset waits for the off trigger
    bus(1, 32'h1C, 32'h8);
    upd(20'h32);
    upd(20'h96);
    chk(sp_out, 1);
    press <= 1'b1;
    repeat (4) @(posedge hclk);
    press <= 1'b0;
    upd(20'h63);
    chk(sp_out, 1);
    upd(20'h62);
    chk(sp_out, 0);
    // a power cycle drops the latch and the pending reset
    upd(20'h96);
    press <= 1'b1;
    repeat (4) @(posedge hclk);
    press <= 1'b0;
    upd(20'h63);
    bus(0, 32'h4, 0);
    chk(rd[3:0], 32'h5);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    chk(sp_out, 0);
    bus(0, 32'h4, 0);
    chk(rd[3:2], 0);
    // standby after power-up holds off until the off side is seen
    bus(1, 32'h1C, 32'h20);
    upd(20'h96);
    chk(sp_out, 0);
    upd(20'h62);
    upd(20'h96);
    chk(sp_out, 1);
    upd(20'h62);
    // open probe drives the burn-out level and flips the colour
    bus(1, 32'h1C, 32'hC0);
    open <= 1'b1;
    repeat (6) @(posedge hclk);
    #1 chk(sp_out, 1);
    chk(backlight_green, 1);
    wrap_up();
  end
endmodule : tb_top
